// ===== common/lhcd_pkg.sv
// Purpose: Shared types and constants of the host command decoder
// Assumes: 100 MHz system clock, byte-wide host link
// Notes:   Opcode patterns are binary since they carry don't-care bits
package lhcd_pkg;
	// Bus modes from the strap pins
	typedef enum logic [1:0] {
		LHCD_BUS_SER = 2'h0,
		LHCD_BUS_I2C = 2'h1,
		LHCD_BUS_80  = 2'h2,
		LHCD_BUS_68  = 2'h3
	} lhcd_bus_t;
	// Strap value on data bits 7:6 that picks three-wire serial
	localparam logic [1:0] LHCD_D76_ALT   = 2'h3;
	// Buffer shape
	localparam int         LHCD_FIFO_W    = 9;
	localparam int         LHCD_FIFO_D    = 8;
	// Serial token length
	localparam logic [2:0] LHCD_BIT_LAST  = 3'h7;
	// Status read sequence length
	localparam logic [1:0] LHCD_STAT_LAST = 2'h2;
	// Neutral identity fields, values arbitrary
	localparam logic [7:0] LHCD_VER_PROD  = 8'h12;
	localparam logic [7:0] LHCD_MAKER_ID  = 8'h5a;
	// Command opcodes; OP_ADV, OP_BIAS, OP_FIX and OP_NINV take a parameter byte
	localparam logic [7:0] OP_COL   = 8'b000?????;
	localparam logic [7:0] OP_TEMP  = 8'b001001??;
	localparam logic [7:0] OP_LOAD  = 8'b001010??;
	localparam logic [7:0] OP_PUMP  = 8'b001011??;
	localparam logic [7:0] OP_ADV   = 8'b001100??;
	localparam logic [7:0] OP_SCRL  = 8'b0100????;
	localparam logic [7:0] OP_SCRH  = 8'b0101????;
	localparam logic [7:0] OP_ROWL  = 8'b0110????;
	localparam logic [7:0] OP_ROWH  = 8'b0111????;
	localparam logic [7:0] OP_BIAS  = 8'b10000001;
	localparam logic [7:0] OP_PART  = 8'b100001??;
	localparam logic [7:0] OP_STEP  = 8'b10001???;
	localparam logic [7:0] OP_FIX   = 8'b10010000;
	localparam logic [7:0] OP_RATE  = 8'b101000??;
	localparam logic [7:0] OP_ALL   = 8'b1010010?;
	localparam logic [7:0] OP_INV   = 8'b1010011?;
	localparam logic [7:0] OP_DEN   = 8'b101011??;
	localparam logic [7:0] OP_MAP   = 8'b11000???;
	localparam logic [7:0] OP_NINV  = 8'b11001000;
	localparam logic [7:0] OP_GRAY  = 8'b11010???;
	localparam logic [7:0] OP_RST   = 8'b11100010;
	localparam logic [7:0] OP_NOP   = 8'b11100011;
	// Highest legal advanced selector
	localparam logic [1:0] LHCD_ADV_MAX = 2'h2;
	// Parameter byte targets of two-byte commands
	typedef enum logic [1:0] {
		LHCD_P_ADV  = 2'h0,
		LHCD_P_BIAS = 2'h1,
		LHCD_P_FIX  = 2'h3,
		LHCD_P_NINV = 2'h2
	} lhcd_par_t;
	// Decoder state, Gray coded
	typedef enum logic {
		LHCD_ST_CMD   = 1'b0,
		LHCD_ST_PARAM = 1'b1
	} lhcd_st_t;
	// Panel settings
	typedef struct packed {
		logic [4:0]      page_column_pointer;
		logic [6:0]      row_pointer;
		logic [6:0]      scroll_origin;
		logic [1:0]      temp_comp;
		logic [1:0]      panel_load;
		logic [1:0]      charge_pump_setting;
		logic [2:0][7:0] advanced_tuning_bytes;
		logic [7:0]      bias_trim_value;
		logic [1:0]      partial_ctl;
		logic [2:0]      address_step_config;
		logic [3:0]      frozen_top_lines;
		logic [3:0]      frozen_bottom_lines;
		logic [1:0]      line_rate;
		logic            all_on;
		logic            inverse;
		logic [1:0]      display_control_bits;
		logic [2:0]      mapping;
		logic [3:0]      line_inversion_count;
		logic [2:0]      gray_shade;
	} lhcd_cfg_t;
	// Documented defaults
	localparam lhcd_cfg_t LHCD_CFG_RST = '{
		page_column_pointer: 5'h00, row_pointer: 7'h00, scroll_origin: 7'h00,
		temp_comp: 2'h0, panel_load: 2'h2, charge_pump_setting: 2'h3,
		advanced_tuning_bytes: 24'h000000, bias_trim_value: 8'h4e,
		partial_ctl: 2'h0, address_step_config: 3'h1, frozen_top_lines: 4'h0,
		frozen_bottom_lines: 4'h0, line_rate: 2'h0, all_on: 1'b0,
		inverse: 1'b0, display_control_bits: 2'h2, mapping: 3'h0,
		line_inversion_count: 4'h6, gray_shade: 3'h1};
	// Synchronised host pins
	typedef struct packed {
		logic       cs_n;
		logic       cd;
		logic [1:0] strobe;
		logic [7:0] data;
	} lhcd_pins_t;
endpackage

// ===== src/lhcd_decoder.sv
// Purpose: Host interface and command decoder of a passive matrix panel
// Assumes: Host pins asynchronous; memory port on the system clock
// Notes:   Operation
// Operation
// - Straps pick parallel, I2C or serial bus; I2C mode ignores host writes and reads
// - Straps 00 pick three- or four-wire serial
// - Strobes follow 6800 or 8080 style
// - Select line marks control or display data
// - Direction flag zero write, one read
// - Hard reset pin low restores defaults
// - Power-on and reset command also reset
// - Data cycles write or read display memory
// - Control read returns status then identity
// - Load page column pointer, default zero
// - Set temperature compensation, default 00
// - Set panel loading and pump control
// - Scroll line from low and high commands
// - Row pointer from low and high commands
// - Partial display and address stepping fields
// - Fixed lines two bytes; line rate field
// - All-pixels-on and inverse display flags
// - Display enable and panel mapping fields
// - Reset command resets; no-op does nothing
`timescale 1ns/1ps

// Byte buffer between host link and decoder
module lhcd_fifo #(
	parameter int W = 9,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         clk_sys_in,
	input  wire logic         sys_rst_in,
	// Fill side
	input  wire logic         in_valid_in,
	input  wire logic [W-1:0] in_data_in,
	output logic              in_ready_out,
	// Drain side
	output logic              out_valid_out,
	output logic [W-1:0]      out_data_out,
	input  wire logic         out_ready_in
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];      // Storage
	logic [AW-1:0] wr_ptr;      // Fill index
	logic [AW-1:0] rd_ptr;      // Drain index
	logic [AW:0]   count;       // Occupancy
	logic          push;
	logic          pop;

	assign in_ready_out  = (count < (AW+1)'(D)); // Room left
	assign out_valid_out = (count != '0);
	assign out_data_out  = mem[rd_ptr];
	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;

	// Storage write
	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

	// Pointers and count
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // lhcd_fifo

module lhcd_decoder import lhcd_pkg::*; (
	// Clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       sys_rst_in,
	input  wire logic       hard_rst_n_in,
	// Host pins
	input  wire logic [1:0] bus_select_pins_in,
	input  wire logic       chip_select_low_in,
	input  wire logic       command_or_pixel_select_in,
	input  wire logic [1:0] host_strobe_in,
	input  wire logic [7:0] data_in,
	output logic [7:0]      data_out,
	output logic            data_oe_n_out,
	// Display memory port
	output logic            mem_wr_out,
	output logic [7:0]      mem_wdata_out,
	input  wire logic       mem_ready_in,
	input  wire logic [7:0] mem_rdata_in,
	// Status and settings
	output lhcd_bus_t       bus_mode_out,
	output logic            three_wire_token_mode_out,
	output logic            fifo_ready_out,
	output lhcd_cfg_t       cfg_out
);
	lhcd_pins_t   s1, s2, s3;     // Synchroniser stages and history
	logic [3:0]   strap_s1;       // Strap sync {bus select, bits 7:6}
	logic [3:0]   strap_s2;       // Strap sync, second stage
	// Deselected idle pins, so no false edge follows reset
	localparam lhcd_pins_t PINS_IDLE = '{cs_n: 1'b1, cd: 1'b0, strobe: 2'h0, data: 8'h00};
	logic [2:0]   rst_pin_sync;   // Hard reset pin sync and history
	logic         strap_done;     // Straps caught
	lhcd_bus_t    mode;           // Selected bus
	logic         three_wire;     // Three-wire serial variant
	logic         push_v;         // Byte to buffer
	logic [8:0]   push_d;         // {select, byte}
	logic [7:0]   shift;          // Serial shift register
	logic [2:0]   bit_cnt;        // Serial bit index
	logic         f_rdy, f_v;
	logic [8:0]   f_d;
	logic         pop;
	lhcd_st_t     state;          // Decoder state
	lhcd_par_t    par_tgt;        // Pending parameter target
	logic [1:0]   adv_sel;        // Pending advanced selector
	lhcd_cfg_t    cfg;            // Live settings
	logic [1:0]   stat_idx;       // Status read position
	logic         rd_act, rd_act_d, wr_evt;
	logic         soft_rst;

	// Two-flop sync of all host pins; s3 keeps history for edges
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s1 <= PINS_IDLE;
			s2 <= PINS_IDLE;
			s3 <= PINS_IDLE;
			strap_s1 <= '0;
			strap_s2 <= '0;
			// Pin reset seen active until the straps have synced
			rst_pin_sync <= '0;
		end else begin
			s1 <= {chip_select_low_in, command_or_pixel_select_in, host_strobe_in, data_in};
			s2 <= s1;
			s3 <= s2;
			strap_s1 <= {bus_select_pins_in, data_in[7:6]};
			strap_s2 <= strap_s1;
			rst_pin_sync <= {rst_pin_sync[1:0], hard_rst_n_in};
		end
	end

	// Strap capture once after reset release
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			strap_done <= 1'b0;
			mode       <= LHCD_BUS_SER;
			three_wire <= 1'b0;
		end else if (!strap_done && rst_pin_sync[1]) begin
			strap_done <= 1'b1;
			mode       <= lhcd_bus_t'(strap_s2[3:2]);
			three_wire <= (strap_s2[3:2] == LHCD_BUS_SER)
				&& (strap_s2[1:0] == LHCD_D76_ALT);
		end
	end

	// Strobe meaning per parallel style; ignored in serial modes
	always_comb begin
		rd_act = 1'b0;
		wr_evt = 1'b0;
		unique case (mode)
			LHCD_BUS_68: begin
				// Enable on strobe 1, direction on strobe 0 (1 = read)
				rd_act = !s2.cs_n && s2.strobe[1] && s2.strobe[0];
				wr_evt = !s2.cs_n && s3.strobe[1] && !s2.strobe[1] && !s3.strobe[0];
			end
			LHCD_BUS_80: begin
				// Low-active read on strobe 1, write on strobe 0
				rd_act = !s2.cs_n && !s2.strobe[1];
				wr_evt = !s2.cs_n && !s3.strobe[0] && s2.strobe[0];
			end
			LHCD_BUS_SER, LHCD_BUS_I2C: begin
				rd_act = 1'b0;
				wr_evt = 1'b0;
			end
		endcase
	end

	// Byte capture: parallel write edge or complete serial token
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			push_v  <= 1'b0;
			push_d  <= '0;
			shift   <= '0;
			bit_cnt <= '0;
		end else begin
			push_v <= 1'b0;
			if (wr_evt) begin
				push_v <= 1'b1;
				push_d <= {s3.cd, s3.data};
			end else if (mode == LHCD_BUS_SER) begin
				if (s2.cs_n) begin
					bit_cnt <= '0;
				end else if (s2.data[0] && !s3.data[0]) begin
					// Rising serial clock on bit 0 samples bit 3, MSB first
					shift   <= {shift[6:0], s2.data[3]};
					bit_cnt <= bit_cnt + 1'b1;
					if (bit_cnt == LHCD_BIT_LAST) begin
						push_v <= 1'b1;
						push_d <= {s2.cd, shift[6:0], s2.data[3]};
					end
				end
			end
		end
	end

	lhcd_fifo #(.W(LHCD_FIFO_W), .D(LHCD_FIFO_D)) u_fifo (
		.clk_sys_in    (clk_sys_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (push_v),
		.in_data_in    (push_d),
		.in_ready_out  (f_rdy),
		.out_valid_out (f_v),
		.out_data_out  (f_d),
		.out_ready_in  (pop)
	);

	// Data bytes stall until memory accepts
	assign pop      = f_v && (!f_d[8] || mem_ready_in);
	assign soft_rst = (!rst_pin_sync[2]) || (pop && !f_d[8] && state == LHCD_ST_CMD
		&& f_d[7:0] == OP_RST);

	// Decoder state and pending target
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state   <= LHCD_ST_CMD;
			par_tgt <= LHCD_P_ADV;
			adv_sel <= '0;
		end else if (soft_rst) begin
			state <= LHCD_ST_CMD;
		end else if (pop && !f_d[8]) begin
			if (state == LHCD_ST_PARAM) begin
				state <= LHCD_ST_CMD;
			end else begin
				casez (f_d[7:0])
					OP_ADV: begin
						// Selector 3 is not legal; its parameter is swallowed
						state   <= LHCD_ST_PARAM;
						par_tgt <= LHCD_P_ADV;
						adv_sel <= f_d[1:0];
					end
					OP_BIAS: begin
						state   <= LHCD_ST_PARAM;
						par_tgt <= LHCD_P_BIAS;
					end
					OP_FIX: begin
						state   <= LHCD_ST_PARAM;
						par_tgt <= LHCD_P_FIX;
					end
					OP_NINV: begin
						state   <= LHCD_ST_PARAM;
						par_tgt <= LHCD_P_NINV;
					end
					default: state <= LHCD_ST_CMD;
				endcase
			end
		end
	end

	// Settings update from commands, parameters and data writes
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cfg <= LHCD_CFG_RST;
		end else if (soft_rst) begin
			cfg <= LHCD_CFG_RST;
		end else if (pop && f_d[8]) begin
			cfg.page_column_pointer <= cfg.page_column_pointer + 1'b1;
		end else if (pop && state == LHCD_ST_PARAM) begin
			unique case (par_tgt)
				LHCD_P_ADV: begin
					if (adv_sel <= LHCD_ADV_MAX) begin
						cfg.advanced_tuning_bytes[adv_sel] <= f_d[7:0];
					end
				end
				LHCD_P_BIAS: cfg.bias_trim_value <= f_d[7:0];
				LHCD_P_FIX: begin
					cfg.frozen_top_lines    <= f_d[7:4];
					cfg.frozen_bottom_lines <= f_d[3:0];
				end
				LHCD_P_NINV: cfg.line_inversion_count <= f_d[3:0];
			endcase
		end else if (pop) begin
			casez (f_d[7:0])
				OP_COL:  cfg.page_column_pointer  <= f_d[4:0];
				OP_TEMP: cfg.temp_comp            <= f_d[1:0];
				OP_LOAD: cfg.panel_load           <= f_d[1:0];
				OP_PUMP: cfg.charge_pump_setting  <= f_d[1:0];
				OP_SCRL: cfg.scroll_origin[3:0]   <= f_d[3:0];
				OP_SCRH: cfg.scroll_origin[6:4]   <= f_d[2:0];
				OP_ROWL: cfg.row_pointer[3:0]     <= f_d[3:0];
				OP_ROWH: cfg.row_pointer[6:4]     <= f_d[2:0];
				OP_PART: cfg.partial_ctl          <= f_d[1:0];
				OP_STEP: cfg.address_step_config  <= f_d[2:0];
				OP_RATE: cfg.line_rate            <= f_d[1:0];
				OP_ALL:  cfg.all_on               <= f_d[0];
				OP_INV:  cfg.inverse              <= f_d[0];
				OP_DEN:  cfg.display_control_bits <= f_d[1:0];
				OP_MAP:  cfg.mapping              <= f_d[2:0];
				OP_GRAY: cfg.gray_shade           <= f_d[2:0];
				default: cfg <= cfg;
			endcase
		end
	end

	// Memory write strobe, one cycle per accepted data byte
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mem_wr_out    <= 1'b0;
			mem_wdata_out <= '0;
		end else begin
			mem_wr_out <= pop && f_d[8];
			if (pop && f_d[8]) begin
				mem_wdata_out <= f_d[7:0];
			end
		end
	end

	// Read path: drive bus while read strobe is active
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_act_d      <= 1'b0;
			data_out      <= '0;
			data_oe_n_out <= 1'b1;
			stat_idx      <= '0;
		end else begin
			rd_act_d      <= rd_act;
			data_oe_n_out <= !rd_act;
			if (rd_act && !rd_act_d) begin
				if (s2.cd) begin
					data_out <= mem_rdata_in;
				end else begin
					unique case (stat_idx)
						2'h0: data_out <= {cfg.mapping[1], cfg.mapping[2], 1'b0,
							cfg.display_control_bits[0], 4'h0};
						2'h1: data_out <= LHCD_VER_PROD;
						default: data_out <= LHCD_MAKER_ID;
					endcase
					stat_idx <= (stat_idx == LHCD_STAT_LAST) ? '0 : stat_idx + 1'b1;
				end
			end else if (wr_evt) begin
				stat_idx <= '0;
			end
		end
	end

	// Registered status outputs
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			bus_mode_out              <= LHCD_BUS_SER;
			three_wire_token_mode_out <= 1'b0;
			fifo_ready_out            <= 1'b0;
			cfg_out                   <= LHCD_CFG_RST;
		end else begin
			bus_mode_out              <= mode;
			three_wire_token_mode_out <= three_wire;
			fifo_ready_out            <= f_rdy;
			cfg_out                   <= cfg;
		end
	end
endmodule // lhcd_decoder

// ===== tb/lhcd_decoder_assertions.sv
// Purpose: Port-level checks of the host command decoder
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Bound into every decoder instance
`timescale 1ns/1ps
module lhcd_decoder_assertions import lhcd_pkg::*; (
	// Clock and resets
	input wire logic       clk_sys_in,
	input wire logic       sys_rst_in,
	input wire logic       hard_rst_n_in,
	// Host side
	input wire logic       chip_select_low_in,
	input wire logic [1:0] host_strobe_in,
	input wire logic       data_oe_n_out,
	// Memory side
	input wire logic       mem_wr_out,
	input wire logic       mem_ready_in,
	// Status and settings
	input wire lhcd_bus_t  bus_mode_out,
	input wire logic       three_wire_token_mode_out,
	input wire logic       fifo_ready_out,
	input wire lhcd_cfg_t  cfg_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	logic [3:0] since_rst; // Cycles since release, saturating
	logic [3:0] quiet;     // Cycles of idle host with memory open
	// Age counter after reset
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			since_rst <= 4'h0;
		end else if (since_rst != 4'hf) begin
			since_rst <= since_rst + 4'h1;
		end
	end
	// Idle counter, cleared by any host or reset activity
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			quiet <= 4'h0;
		end else if (!chip_select_low_in || !hard_rst_n_in || !mem_ready_in) begin
			quiet <= 4'h0;
		end else if (quiet != 4'hf) begin
			quiet <= quiet + 4'h1;
		end
	end
	a_mode_set_once: assert property (($changed(bus_mode_out) ||
		$changed(three_wire_token_mode_out)) |-> since_rst < 4'h9)
		else $error("bus mode moved long after reset");
	a_three_wire_ser: assert property (three_wire_token_mode_out |->
		bus_mode_out == LHCD_BUS_SER) else $error("three-wire flag outside serial");
	a_wr_needs_ready: assert property (mem_wr_out |-> $past(mem_ready_in))
		else $error("memory write while memory stalled");
	a_read_parallel: assert property (!data_oe_n_out |->
		bus_mode_out inside {LHCD_BUS_80, LHCD_BUS_68}) else $error("drive outside parallel");
	a_i2c_quiet: assert property (bus_mode_out == LHCD_BUS_I2C |->
		!mem_wr_out && data_oe_n_out && $stable(cfg_out)) else $error("activity in i2c mode");
	a_reset_defaults: assert property ($fell(sys_rst_in) |->
		cfg_out == LHCD_CFG_RST) else $error("settings not default after reset");
	a_hard_pin_dflt: assert property (!hard_rst_n_in [*8] |->
		cfg_out == LHCD_CFG_RST) else $error("settings kept under pin reset");
	a_cfg_idle_hold: assert property (quiet > 4'hd |-> $stable(cfg_out))
		else $error("settings moved with host idle");
	c_mem_wr: cover property (mem_wr_out);
	c_read: cover property (!data_oe_n_out);
	c_full: cover property (!fifo_ready_out);
	c_three: cover property (three_wire_token_mode_out);
endmodule // lhcd_decoder_assertions

bind lhcd_decoder lhcd_decoder_assertions chk (.clk_sys_in(clk_sys_in),
	.sys_rst_in(sys_rst_in), .hard_rst_n_in(hard_rst_n_in),
	.chip_select_low_in(chip_select_low_in), .host_strobe_in(host_strobe_in),
	.data_oe_n_out(data_oe_n_out), .mem_wr_out(mem_wr_out), .mem_ready_in(mem_ready_in),
	.bus_mode_out(bus_mode_out), .three_wire_token_mode_out(three_wire_token_mode_out),
	.fifo_ready_out(fifo_ready_out), .cfg_out(cfg_out));

// ===== tb/lhcd_host_model.sv
// Purpose: Host controller model driving the panel bus pins
// Assumes: Called at the falling clock edge
// Notes:   Released data lines show the inverse of the last parallel byte written
`timescale 1ns/1ps
module lhcd_host_model import lhcd_pkg::*; (
	// Clock and mode
	input  wire logic       clk_sys_in,
	input  wire lhcd_bus_t  style_in,
	input  wire logic [1:0] d76_in,
	// Read return
	input  wire logic       oe_n_in,
	input  wire logic [7:0] rdata_in,
	// Bus pins
	output logic            cs_low_out,
	output logic            cd_out,
	output logic [1:0]      strobe_out,
	output logic [7:0]      data_out
);
	wire logic [1:0] idl = (style_in == LHCD_BUS_80) ? 2'h3 : 2'h0; // Parked strobes
	// Phase wait, longer than the pin synchroniser
	task automatic ph(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	// Pins parked, straps on bits 7:6
	task automatic park(input logic [1:0] st, input logic [1:0] sd);
		cs_low_out = 1'b1;
		cd_out = 1'b0;
		strobe_out = st;
		data_out = {sd, 6'h2a};
	endtask
	initial park(2'h3, 2'h0);
	// Parallel write, same active strobe code in both styles
	task automatic wr(input logic c, input logic [7:0] v);
		cs_low_out = 1'b0;
		cd_out = c;
		data_out = v;
		ph(4);
		strobe_out = 2'h2;
		ph(4);
		strobe_out = idl;
		ph(4);
		cs_low_out = 1'b1;
		data_out = ~v;
		ph(2);
	endtask
	// Parallel read, bounded wait for the device to drive
	task automatic rd(input logic c, output logic [7:0] v);
		int n = 0;
		cs_low_out = 1'b0;
		cd_out = c;
		ph(4);
		strobe_out = (style_in == LHCD_BUS_80) ? 2'h1 : 2'h3;
		while (oe_n_in !== 1'b0 && n < 12) begin
			ph(1);
			n++;
		end
		ph(1);
		v = rdata_in;
		strobe_out = idl;
		ph(4);
		cs_low_out = 1'b1;
		ph(2);
	endtask
	// Serial control byte, MSB first, clock still outside the frame
	task automatic ser(input logic [7:0] v);
		cs_low_out = 1'b0;
		cd_out = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			data_out = {d76_in, 2'h0, v[i], 3'h0};
			ph(8);
			data_out[0] = 1'b1;
			ph(8);
		end
		data_out = {d76_in, 2'h0, ~v[0], 3'h0};
		ph(8);
		cs_low_out = 1'b1;
	endtask
endmodule // lhcd_host_model

// ===== tb/lhcd_decoder_tb.sv
// Purpose: Self-checking bench of the host command decoder
// Assumes: 100 MHz clock, host model on the pins
// Notes:   A bus mode change needs a fresh reset
`timescale 1ns/1ps
module lhcd_decoder_tb import lhcd_pkg::*;;
	logic       clk_sys_in = 1'b0, sys_rst_in = 1'b1, hard_rst_n_in = 1'b1;
	logic       mem_ready_in = 1'b1, cs_low, cd, data_oe_n_out, mem_wr_out;
	logic       three_wire_token_mode_out, fifo_ready_out;
	logic [1:0] bus_select_pins_in = 2'h2, d76 = 2'h0, strobe;
	logic [7:0] hdata, data_in, data_out, mem_wdata_out, last_w, mem_rdata_in = 8'hc3;
	lhcd_bus_t  mode = LHCD_BUS_80, bus_mode_out;
	lhcd_cfg_t  cfg_out, e;
	int         errors = 0, n_compared = 0, n_wr = 0, cyc = 0;
	assign data_in = data_oe_n_out ? hdata : data_out; // Shared bus level
	lhcd_decoder dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.hard_rst_n_in(hard_rst_n_in), .bus_select_pins_in(bus_select_pins_in),
		.chip_select_low_in(cs_low), .command_or_pixel_select_in(cd),
		.host_strobe_in(strobe), .data_in(data_in), .data_out(data_out),
		.data_oe_n_out(data_oe_n_out), .mem_wr_out(mem_wr_out),
		.mem_wdata_out(mem_wdata_out), .mem_ready_in(mem_ready_in),
		.mem_rdata_in(mem_rdata_in), .bus_mode_out(bus_mode_out),
		.three_wire_token_mode_out(three_wire_token_mode_out),
		.fifo_ready_out(fifo_ready_out), .cfg_out(cfg_out));
	lhcd_host_model host (.clk_sys_in(clk_sys_in), .style_in(mode), .d76_in(d76),
		.oe_n_in(data_oe_n_out), .rdata_in(data_in), .cs_low_out(cs_low),
		.cd_out(cd), .strobe_out(strobe), .data_out(hdata));
	initial forever #5 clk_sys_in = ~clk_sys_in;
	// Verdict and end of run
	task automatic tally_and_finish();
		$display("compared %0d, wrong %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Hang guard and memory write monitor
	always @(posedge clk_sys_in) begin
		cyc++;
		if (mem_wr_out === 1'b1) begin
			n_wr++;
			last_w = mem_wdata_out;
		end
		if (cyc == 10000) begin
			errors++;
			tally_and_finish();
		end
	end
	// Compare and report
	task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// Reset with new straps held across release
	task automatic restart(input logic [1:0] bm, input logic [1:0] sd);
		@(negedge clk_sys_in);
		sys_rst_in = 1'b1;
		bus_select_pins_in = bm;
		d76 = sd;
		mode = lhcd_bus_t'(bm);
		host.park((bm == 2'h2) ? 2'h3 : 2'h0, sd);
		host.ph(12);
		sys_rst_in = 1'b0;
		host.ph(8);
	endtask
	task automatic t_single();
		logic [7:0] c [16] = '{8'h0b, 8'h26, 8'h28, 8'h2d, 8'h4a, 8'h5b, 8'h65, 8'h7f,
			8'h87, 8'h8e, 8'ha1, 8'ha5, 8'ha7, 8'hac, 8'hc5, 8'hd4};
		chk(bus_mode_out, LHCD_BUS_80, "mode");
		chk(cfg_out, LHCD_CFG_RST, "defaults");
		foreach (c[i]) host.wr(1'b0, c[i]);
		host.ph(6);
		e = LHCD_CFG_RST;
		e.page_column_pointer = 5'h0b;
		e.temp_comp = 2'h2;
		e.panel_load = 2'h0;
		e.charge_pump_setting = 2'h1;
		e.scroll_origin = 7'h3a;
		e.row_pointer = 7'h75;
		e.partial_ctl = 2'h3;
		e.address_step_config = 3'h6;
		e.line_rate = 2'h1;
		e.all_on = 1'b1;
		e.inverse = 1'b1;
		e.display_control_bits = 2'h0;
		e.mapping = 3'h5;
		e.gray_shade = 3'h4;
		chk(cfg_out, e, "single");
		$display("single byte commands done");
	endtask
	task automatic t_pairs();
		logic [7:0] c [12] = '{8'h81, 8'h77, 8'h90, 8'h52, 8'hc8, 8'h0b, 8'h30, 8'h11,
			8'h32, 8'he2, 8'h33, 8'h99};
		host.wr(1'b0, c[0]);
		host.wr(1'b1, 8'haa);
		for (int i = 1; i < 12; i++) host.wr(1'b0, c[i]);
		host.wr(1'b0, 8'he3);
		host.ph(6);
		e.page_column_pointer = 5'h0c;
		e.bias_trim_value = 8'h77;
		e.frozen_top_lines = 4'h5;
		e.frozen_bottom_lines = 4'h2;
		e.line_inversion_count = 4'hb;
		e.advanced_tuning_bytes[0] = 8'h11;
		e.advanced_tuning_bytes[2] = 8'he2;
		chk(cfg_out, e, "pairs");
		chk(last_w, 8'haa, "data byte");
		$display("two byte commands done");
	endtask
	task automatic t_fifo_reads();
		logic [7:0] v;
		mem_ready_in = 1'b0;
		for (int i = 1; i <= 10; i++) host.wr(1'b1, 8'(i));
		chk(fifo_ready_out, 1'b0, "buffer full");
		n_wr = 0;
		mem_ready_in = 1'b1;
		host.ph(20);
		chk(n_wr, 8, "drained count");
		chk(last_w, 8'h08, "last drained");
		chk(fifo_ready_out, 1'b1, "buffer empty");
		e.page_column_pointer = 5'h14;
		chk(cfg_out, e, "column steps");
		host.rd(1'b0, v);
		chk(v, 8'h40, "status");
		host.rd(1'b0, v);
		chk(v, LHCD_VER_PROD, "version");
		host.rd(1'b0, v);
		chk(v, LHCD_MAKER_ID, "maker");
		host.rd(1'b1, v);
		chk(v, 8'hc3, "memory read");
		mem_rdata_in = 8'h3c;
		host.rd(1'b1, v);
		chk(v, 8'h3c, "memory read");
		$display("buffer and reads done");
	endtask
	task automatic t_resets();
		host.wr(1'b0, 8'he2);
		host.ph(6);
		chk(cfg_out, LHCD_CFG_RST, "reset command");
		host.wr(1'b0, 8'ha5);
		host.wr(1'b0, 8'he3);
		host.ph(6);
		e = LHCD_CFG_RST;
		e.all_on = 1'b1;
		chk(cfg_out, e, "no-op");
		hard_rst_n_in = 1'b0;
		host.ph(10);
		chk(cfg_out, LHCD_CFG_RST, "pin reset");
		hard_rst_n_in = 1'b1;
		host.ph(6);
		chk(bus_mode_out, LHCD_BUS_80, "straps kept");
		$display("resets done");
	endtask
	task automatic t_modes();
		restart(2'h3, 2'h0);
		host.wr(1'b0, 8'hd6);
		host.ph(6);
		chk(bus_mode_out, LHCD_BUS_68, "6800 mode");
		chk(cfg_out.gray_shade, 3'h6, "6800 write");
		restart(2'h0, 2'h3);
		chk(three_wire_token_mode_out, 1'b1, "three-wire");
		host.ser(8'h25);
		host.ph(8);
		chk(cfg_out.temp_comp, 2'h1, "three-wire byte");
		restart(2'h0, 2'h0);
		chk(three_wire_token_mode_out, 1'b0, "four-wire");
		host.ser(8'h29);
		host.ph(8);
		chk(cfg_out.panel_load, 2'h1, "four-wire byte");
		restart(2'h1, 2'h3);
		chk(bus_mode_out, LHCD_BUS_I2C, "i2c mode");
		host.wr(1'b0, 8'hd6);
		host.ph(6);
		chk(cfg_out, LHCD_CFG_RST, "i2c idle");
		$display("bus modes done");
	endtask
	// Main sequence
	initial begin
		restart(2'h2, 2'h0);
		t_single();
		t_pairs();
		t_fifo_reads();
		t_resets();
		t_modes();
		tally_and_finish();
	end
endmodule // lhcd_decoder_tb
